// ===== scrc_map.svh
// Purpose: Offsets, reset values and timing counts of the strap and serial ROM loader.
// Assumes: 25 MHz core clock.
// Notes:   Counts derive from times given in ns.
`ifndef SCRC_MAP_SVH
`define SCRC_MAP_SVH

// Config space offset of the reference clock disable register
`define SCRC_CLKDIS_OFF   8'h98
`define SCRC_CLK_NS       40
// Least half period of the serial ROM clock
`define SCRC_ROM_HALF_NS  500
`define SCRC_ROM_HALF_CYC ((`SCRC_ROM_HALF_NS + `SCRC_CLK_NS - 1) / `SCRC_CLK_NS)
// Read command: start bit, opcode, address
`define SCRC_CMD_READ     3'h6
`define SCRC_ROM_ADDR     6'h00
`define SCRC_CMD_LEN      9
`define SCRC_DATA_LEN     16
// Max payload capability codes
`define SCRC_MPS_256      3'h1
`define SCRC_MPS_512      3'h2
`define SCRC_CFG_DEFAULT  16'h0000
`define SCRC_UPS_RESET    4'h0

`endif

// ===== scrc_pkg.sv
// Purpose: Types of the strap and serial ROM loader.
// Assumes: Nothing.
// Notes:   One-hot state codes.
package scrc_pkg;
    typedef enum logic [3:0] {
        ST_BOOT = 4'h1,
        ST_SEND = 4'h2,
        ST_RECV = 4'h4,
        ST_DONE = 4'h8
    } scrc_state_e;
    typedef logic [3:0] scrc_port_t;
    typedef logic [2:0] scrc_mps_t;
endpackage : scrc_pkg

// ===== scrc_top.sv
// Purpose: Strap capture, reference clock gating, serial ROM read, management pins.
// Assumes: Single 25 MHz clock, synchronous active-low reset.
// Notes:   Pin inputs pass a two-stage synchroniser first.
//
// How it works
// - A reference clock output is enabled only while its request input is held low.
// - A config disable bit turns a reference clock off regardless of its request.
// - The four upstream select straps choose which port is upstream.
// - The payload strap high advertises 512 bytes, low advertises 256 bytes.
// - The ROM select pin is read as a strap at start-up; low bypasses the ROM.
// - The block masters the serial ROM and drives its clock.
// - Command bits leave on the outgoing serial ROM data line.
// - Data returned by the ROM is captured from the incoming serial ROM data line.
// - The active-low ROM select is asserted during a transfer, driven high after a read and released otherwise.
// - The management port watches its open-drain clock and data lines and leaves them released.
// - System reset initialises straps, serial ROM logic and all other state except the pin synchronisers.
`timescale 1ns/1ns
`include "scrc_map.svh"

module scrc_top #(
    parameter int         NPORTS      = 6,
    parameter logic [15:0] CFG_DEFAULT = `SCRC_CFG_DEFAULT
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [NPORTS-1:0]     clock_request_n,
    input  wire logic [NPORTS-1:0]     refclk_disable,
    output wire logic [NPORTS-1:0]     refclk_enable,
    input  wire logic [3:0]            upstream_port_select,
    input  wire logic                  payload_cap_strap,
    output wire scrc_pkg::scrc_port_t  upstream_port,
    output wire scrc_pkg::scrc_mps_t   max_payload_cap,
    output wire logic                  serial_rom_clock,
    output wire logic                  serial_rom_data_out,
    input  wire logic                  serial_rom_data_in,
    input  wire logic                  serial_rom_select_n_in,
    output wire logic                  serial_rom_select_n,
    output wire logic                  serial_rom_select_oe_n,
    output wire logic                  rom_enabled,
    output wire logic [15:0]           rom_config,
    output wire logic                  config_done,
    input  wire logic                  smb_clock_in,
    output wire logic                  smb_clock_oe_n,
    input  wire logic                  smb_data_in,
    output wire logic                  smb_data_oe_n,
    output wire logic                  smb_busy
);
    import scrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    localparam int         PW       = NPORTS + 9;
    localparam logic [4:0] HALF_M1  = 5'(`SCRC_ROM_HALF_CYC - 1);
    localparam logic [4:0] CMD_LAST = 5'(`SCRC_CMD_LEN - 1);
    localparam logic [4:0] DAT_LAST = 5'(`SCRC_DATA_LEN - 1);

    logic [PW-1:0]     sync1_r;
    logic [PW-1:0]     sync2_r;
    scrc_state_e       state_r;
    scrc_state_e       state_nxt;
    logic [4:0]        div_cnt_r;
    logic              sck_r;
    logic [4:0]        bit_cnt_r;
    logic [8:0]        cmd_r;
    logic [15:0]       data_r;
    logic [15:0]       cfg_r;
    logic              done_r;
    scrc_port_t        ups_r;
    scrc_mps_t         mps_r;
    logic              rom_en_r;
    logic [NPORTS-1:0] refclk_en_r;
    logic              sel_r;
    logic              sel_oe_n_r;
    logic              sda_d_r;
    logic              smb_busy_r;
    logic              scl_oe_n_r;
    logic              sda_oe_n_r;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers run through reset so the straps are settled at release
    wire [PW-1:0] pins_w = {clock_request_n, upstream_port_select, payload_cap_strap,
                            serial_rom_data_in, serial_rom_select_n_in,
                            smb_clock_in, smb_data_in};

    always_ff @(posedge clk) begin
        sync1_r <= pins_w;
        sync2_r <= sync1_r;
    end

    wire              sda_s = sync2_r[0];
    wire              scl_s = sync2_r[1];
    wire              sel_s = sync2_r[2];
    wire              din_s = sync2_r[3];
    wire              pl_s  = sync2_r[4];
    wire [3:0]        ups_s = sync2_r[8:5];
    wire [NPORTS-1:0] req_s = sync2_r[PW-1:9];

    ////////////////////////////////////////////////////////////////////////////
    // Reference clock gating
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            refclk_en_r <= '0;
        end else begin
            refclk_en_r <= ~(req_s | refclk_disable);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture, only in the boot cycle after release
    wire boot_w = (state_r == ST_BOOT);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ups_r    <= `SCRC_UPS_RESET;
            mps_r    <= `SCRC_MPS_256;
            rom_en_r <= 1'b0;
        end else if (boot_w) begin
            ups_r    <= ups_s;
            mps_r    <= pl_s ? `SCRC_MPS_512 : `SCRC_MPS_256;
            rom_en_r <= sel_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial ROM sequencer
    wire busy_w     = (state_r == ST_SEND) || (state_r == ST_RECV);
    wire tick_w     = busy_w && (div_cnt_r == HALF_M1);
    wire fall_w     = tick_w && sck_r;
    wire last_cmd_w = (bit_cnt_r == CMD_LAST);
    wire last_dat_w = (bit_cnt_r == DAT_LAST);
    wire send_nxt_w = (state_nxt == ST_SEND) || (state_nxt == ST_RECV);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_BOOT: state_nxt = sel_s ? ST_SEND : ST_DONE;
            ST_SEND: begin
                if (fall_w && last_cmd_w) begin
                    state_nxt = ST_RECV;
                end
            end
            ST_RECV: begin
                if (fall_w && last_dat_w) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: state_nxt = ST_DONE;
            default: state_nxt = ST_BOOT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_BOOT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Divider yields the ROM clock half period as an enable
    always_ff @(posedge clk) begin
        if (!rst_b || !busy_w || tick_w) begin
            div_cnt_r <= 5'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || !busy_w) begin
            sck_r <= 1'b0;
        end else if (tick_w) begin
            sck_r <= ~sck_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || boot_w) begin
            bit_cnt_r <= 5'h00;
        end else if (fall_w) begin
            bit_cnt_r <= (state_r == ST_SEND && last_cmd_w) ? 5'h00 : bit_cnt_r + 5'h01;
        end
    end

    // Command shifts on the falling edge, ROM samples on the rising one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd_r <= 9'h000;
        end else if (boot_w && sel_s) begin
            // Bypassed ROM keeps its data pin idle low
            cmd_r <= {`SCRC_CMD_READ, `SCRC_ROM_ADDR};
        end else if (fall_w && state_r == ST_SEND) begin
            cmd_r <= {cmd_r[7:0], 1'b0};
        end
    end

    // Sampled just before the falling edge, a full half period after the rise
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_r <= 16'h0000;
        end else if (fall_w && state_r == ST_RECV) begin
            data_r <= {data_r[14:0], din_s};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_r <= CFG_DEFAULT;
        end else if (fall_w && state_r == ST_RECV && last_dat_w) begin
            cfg_r <= {data_r[14:0], din_s};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_nxt == ST_DONE);
        end
    end

    // Select stays released while bypassed, the board ties it low then
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_oe_n_r <= 1'b1;
            sel_r      <= 1'b1;
        end else begin
            if (boot_w) begin
                sel_oe_n_r <= ~sel_s;
            end
            sel_r <= ~send_nxt_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Management port: bus watch only, lines left released
    wire start_w = scl_s && sda_d_r && !sda_s;
    wire stop_w  = scl_s && !sda_d_r && sda_s;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sda_d_r    <= 1'b1;
            smb_busy_r <= 1'b0;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
        end else begin
            sda_d_r <= sda_s;
            if (start_w) begin
                smb_busy_r <= 1'b1;
            end else if (stop_w) begin
                smb_busy_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign refclk_enable          = refclk_en_r;
    assign upstream_port          = ups_r;
    assign max_payload_cap        = mps_r;
    assign serial_rom_clock       = sck_r;
    assign serial_rom_data_out    = cmd_r[8];
    assign serial_rom_select_n    = sel_r;
    assign serial_rom_select_oe_n = sel_oe_n_r;
    assign rom_enabled            = rom_en_r;
    assign rom_config             = cfg_r;
    assign config_done            = done_r;
    assign smb_clock_oe_n         = scl_oe_n_r;
    assign smb_data_oe_n          = sda_oe_n_r;
    assign smb_busy               = smb_busy_r;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_boot_rom;
        (state_r == ST_BOOT) && sel_s;
    endsequence

    sequence s_boot_bypass;
        (state_r == ST_BOOT) && !sel_s;
    endsequence

    a_clkreq_low: assert property (|(refclk_en_r & $past(req_s)) == 1'b0)
        else $error("clock enabled without request");
    a_clk_disable: assert property (|(refclk_en_r & $past(refclk_disable)) == 1'b0)
        else $error("disabled clock still enabled");
    a_ups_strap: assert property (boot_w |=> ups_r == $past(ups_s))
        else $error("upstream port not from strap");
    a_payload_cap: assert property (boot_w |=>
        mps_r == ($past(pl_s) ? `SCRC_MPS_512 : `SCRC_MPS_256))
        else $error("payload capability wrong");
    a_bypass_strap: assert property (s_boot_bypass |=>
        state_r == ST_DONE && !rom_en_r && sel_oe_n_r && cfg_r == CFG_DEFAULT)
        else $error("bypass not honoured");
    a_clock_idle: assert property (!busy_w |-> !sck_r)
        else $error("ROM clock toggles outside read");
    a_data_stable: assert property ($rose(sck_r) && state_r == ST_SEND |->
        $stable(cmd_r[8]))
        else $error("data out moved at rising edge");
    a_data_capture: assert property (fall_w && state_r == ST_RECV |=>
        data_r[0] == $past(din_s))
        else $error("ROM data not captured");
    a_select_frame: assert property (busy_w |-> !sel_r && !sel_oe_n_r)
        else $error("select not asserted in transfer");
    a_smb_release: assert property (scl_oe_n_r && sda_oe_n_r)
        else $error("management lines driven");
    a_smb_start: assert property (start_w |=> smb_busy_r)
        else $error("bus start not seen");
    a_reset_init: assert property (disable iff (1'b0) !rst_b |=>
        state_r == ST_BOOT && !done_r && sel_r && sel_oe_n_r && !sck_r)
        else $error("reset did not initialise");
    a_strap_hold: assert property (!boot_w |=>
        $stable(ups_r) && $stable(mps_r) && $stable(rom_en_r))
        else $error("strap changed after boot");
    a_boot_read: assert property (s_boot_rom |=> state_r == ST_SEND && !done_r)
        else $error("ROM read not started");
    a_read_bound: assert property (s_boot_rom |=> ##[1:1000] done_r)
        else $error("ROM read did not finish");

endmodule : scrc_top

// ===== scrc_rom_model.sv
// Purpose: Serial ROM on the far side of the loader.
// Assumes: Read command of 9 bits, then 16 data bits, MSB first.
// Notes:   Released output shows the inverse of its last value.
`timescale 1ns/1ns
module scrc_rom_model (
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic        slow,
    input  wire logic [15:0] word,
    output logic             dout,
    output logic [8:0]       cmd,
    output int               rises
);
    int   cnt;
    logic last;
    initial begin
        dout = 1'b1;
        last = 1'b1;
        cnt = 0;
        rises = 0;
        cmd = 9'h000;
    end
    always @(negedge cs_n) begin
        cnt = 0;
        rises = 0;
        cmd = 9'h000;
    end
    // No pull on this line, so never leave the old bit showing
    always @(posedge cs_n) dout = ~last;
    always @(posedge sck) begin
        if (!cs_n) begin
            rises = rises + 1;
            if (cnt < 9) begin
                cmd = {cmd[7:0], din};
            end else begin
                // Slow answer still inside the sampling margin
                if (slow) #300;
                // Select may drop during the delay; then keep the line released
                if (!cs_n) begin
                    last = word[24 - cnt];
                    dout = last;
                end
            end
            cnt = cnt + 1;
        end
    end
endmodule : scrc_rom_model

// ===== testbench.sv
// Purpose: Self-checking bench of the strap and serial ROM loader.
// Assumes: 25 MHz clock, inputs changed at the falling edge.
// Notes:   Select pin level is worked out from the strap and the drive.
`timescale 1ns/1ns
`include "scrc_map.svh"
module testbench;
    import scrc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, pl = 1'b0, strap = 1'b0;
    logic scl = 1'b1, sda = 1'b1, slow = 1'b0;
    logic [5:0] req_n = 6'h3F, dis = 6'h00;
    logic [3:0] ups = 4'h0;
    logic [15:0] word = 16'h0000;
    int err_count = 0, n_compared = 0;
    wire [5:0] ref_en;
    wire [15:0] rom_cfg;
    wire [8:0] cmd;
    int rises;
    scrc_port_t up_port;
    scrc_mps_t mps;
    wire sck, sdo, sdi, sel_n, sel_oe_n, rom_en, done, scl_oe_n, sda_oe_n, busy;
    wire sel_in = sel_oe_n ? strap : sel_n;
    always #20 clk = ~clk;
    scrc_top u_dut (.clk(clk), .rst_b(rst_b), .clock_request_n(req_n),
        .refclk_disable(dis), .refclk_enable(ref_en), .upstream_port_select(ups),
        .payload_cap_strap(pl), .upstream_port(up_port), .max_payload_cap(mps),
        .serial_rom_clock(sck), .serial_rom_data_out(sdo), .serial_rom_data_in(sdi),
        .serial_rom_select_n_in(sel_in), .serial_rom_select_n(sel_n),
        .serial_rom_select_oe_n(sel_oe_n), .rom_enabled(rom_en), .rom_config(rom_cfg),
        .config_done(done), .smb_clock_in(scl & scl_oe_n), .smb_clock_oe_n(scl_oe_n),
        .smb_data_in(sda & sda_oe_n), .smb_data_oe_n(sda_oe_n), .smb_busy(busy));
    scrc_rom_model u_rom (.sck(sck), .cs_n(sel_n | sel_oe_n), .din(sdo), .slow(slow),
        .word(word), .dout(sdi), .cmd(cmd), .rises(rises));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic boot(input logic s, input logic [3:0] u, input logic p);
        @(negedge clk);
        rst_b = 1'b0;
        strap = s;
        ups = u;
        pl = p;
        repeat (8) @(negedge clk);
        chk({done, sel_oe_n, sel_n, sck, rom_en, busy, mps, up_port},
            {6'h18, `SCRC_MPS_256, `SCRC_UPS_RESET});
        chk(rom_cfg, `SCRC_CFG_DEFAULT);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        // Straps flip once latched; outputs must not follow
        strap = ~s;
        ups = ~u;
        pl = ~p;
    endtask : boot
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_bypass();
        boot(1'b0, 4'hA, 1'b0);
        repeat (20) @(negedge clk);
        chk(up_port, 4'hA);
        chk(mps, `SCRC_MPS_256);
        chk({rom_en, done, sel_oe_n, sck, sdo}, 5'h0C);
        chk(rom_cfg, `SCRC_CFG_DEFAULT);
    endtask : t_bypass
    task automatic t_read(input logic s, input logic [15:0] w);
        int n;
        slow = s;
        word = w;
        boot(1'b1, 4'h5, 1'b1);
        chk({sel_oe_n, sel_n, sdo}, 3'h1);
        n = 0;
        while (done !== 1'b1 && n < 800) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n < 700), 16'h0001);
        chk(16'(cmd), {7'h00, `SCRC_CMD_READ, `SCRC_ROM_ADDR});
        chk(rom_cfg, w);
        chk(rises[15:0], 16'h0019);
        chk({rom_en, mps, up_port, sel_n, sck}, {1'b1, `SCRC_MPS_512, 4'h5, 2'h2});
    endtask : t_read
    task automatic t_abort();
        boot(1'b1, 4'h3, 1'b0);
        repeat (300) @(negedge clk);
        chk({sel_oe_n, sel_n, done}, 3'h0);
        t_bypass();
    endtask : t_abort
    task automatic t_refclk();
        for (int i = 0; i < 6; i++) begin
            req_n = ~(6'h01 << i);
            repeat (4) @(negedge clk);
            chk(16'(ref_en), 16'h0001 << i);
            dis = 6'h01 << i;
            repeat (2) @(negedge clk);
            chk(16'(ref_en), 16'h0000);
            dis = 6'h00;
        end
        req_n = 6'h3F;
        repeat (4) @(negedge clk);
        chk(16'(ref_en), 16'h0000);
    endtask : t_refclk
    task automatic t_smb();
        sda = 1'b0;
        repeat (6) @(negedge clk);
        chk({busy, scl_oe_n, sda_oe_n}, 3'h7);
        // Bus clock of 320 ns only inside the frame
        repeat (3) begin
            scl = 1'b0;
            repeat (4) @(negedge clk);
            scl = 1'b1;
            repeat (4) @(negedge clk);
        end
        chk(busy, 1'b1);
        sda = 1'b1;
        repeat (6) @(negedge clk);
        chk({busy, scl_oe_n, sda_oe_n}, 3'h3);
    endtask : t_smb
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        err_count++;
        stop_test();
    end
    initial begin
        t_bypass();
        t_refclk();
        t_smb();
        t_read(1'b0, 16'hA5C3);
        t_read(1'b1, 16'h3C5A);
        t_abort();
        stop_test();
    end
endmodule : testbench
